/* File: core/timer_base_pkg.sv */
// package: register map, reset values, field layouts and types for the timer base and complementary outputs
package timer_base_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_COUNT    = 8'h24;
  localparam logic [7:0] OFS_PRESCALE = 8'h28;
  localparam logic [7:0] OFS_RELOAD   = 8'h2c;
  localparam logic [7:0] OFS_REPEAT   = 8'h30;
  localparam logic [7:0] OFS_OUTCTRL  = 8'h44;
  localparam logic [7:0] OFS_MODE     = 8'h48;
  localparam logic [7:0] OFS_EVTGEN   = 8'h4c;
  localparam logic [7:0] OFS_STATUS   = 8'h50;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_COUNT    = 16'h0000;
  localparam logic [15:0] RST_PRESCALE = 16'h0000;
  localparam logic [15:0] RST_RELOAD   = 16'hffff;
  localparam logic [7:0]  RST_REPEAT   = 8'h00;
  localparam logic [7:0]  RST_DEADTIME = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // output control word
  localparam int OC_PRI_EN   = 0;
  localparam int OC_PRI_POL  = 1;
  localparam int OC_CMP_EN   = 2;
  localparam int OC_CMP_POL  = 3;
  localparam int OC_PRI_IDLE = 4;
  localparam int OC_CMP_IDLE = 5;
  localparam int OC_RUN_OFF  = 6;
  localparam int OC_IDLE_OFF = 7;
  localparam int OC_MAIN_EN  = 8;
  localparam int OC_DT_LSB   = 16;
  // mode word
  localparam int MD_ENABLE   = 0;
  localparam int MD_DIR_DOWN = 1;
  localparam int MD_CENTER   = 2;
  // event generation word
  localparam int EG_UPDATE   = 0;

  typedef enum logic [2:0] {
    DT_IDLE = 3'b001,
    DT_WAIT = 3'b010,
    DT_DONE = 3'b100
  } idle_state_e;

  typedef struct packed {
    logic priOut;
    logic priDrive;
    logic cmpOut;
    logic cmpDrive;
  } pin_pair_s;

endpackage : timer_base_pkg

/* File: core/timer_base_outputs.sv */
// module: timer time base with one complementary output pair, on an AHB-Lite slave
module timer_base_outputs
  import timer_base_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int REP_W = 8
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // waveform in and pins out
  input  wire logic        reference_waveform,
  output pin_pair_s        pins,
  output logic             updateEvent
);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic       wrPend;
  logic [7:0] wrAddr;
  logic       addrPhase;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrPhase = hsel && hready && htrans[1];

  // writes land at the data-phase edge, when hwdata stands
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPend <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr <= haddr[7:0];
      end
    end
  end

  logic wrCount;
  logic wrPresc;
  logic wrReload;
  logic wrRepeat;
  logic wrOut;
  logic wrMode;
  logic wrEvt;
  assign wrCount  = wrPend && (wrAddr == OFS_COUNT);
  assign wrPresc  = wrPend && (wrAddr == OFS_PRESCALE);
  assign wrReload = wrPend && (wrAddr == OFS_RELOAD);
  assign wrRepeat = wrPend && (wrAddr == OFS_REPEAT);
  assign wrOut    = wrPend && (wrAddr == OFS_OUTCTRL);
  assign wrMode   = wrPend && (wrAddr == OFS_MODE);
  assign wrEvt    = wrPend && (wrAddr == OFS_EVTGEN);

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] prescale_divider;
  logic [CNT_W-1:0] reload_value;
  logic [REP_W-1:0] repetition_setting;
  logic [8:0]       outCtrl;
  logic [7:0]       deadTime;
  logic [2:0]       mode;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prescale_divider   <= RST_PRESCALE;
      reload_value       <= RST_RELOAD;
      repetition_setting <= RST_REPEAT;
      outCtrl            <= '0;
      deadTime           <= RST_DEADTIME;
      mode               <= '0;
    end else begin
      if (wrPresc) prescale_divider <= hwdata[CNT_W-1:0];
      if (wrReload) reload_value <= hwdata[CNT_W-1:0];
      if (wrRepeat) repetition_setting <= hwdata[REP_W-1:0];
      if (wrOut) begin
        outCtrl  <= hwdata[8:0];
        deadTime <= hwdata[OC_DT_LSB+:8];
      end
      if (wrMode) mode <= hwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] counter_value;
  logic [CNT_W-1:0] activePresc;
  logic [CNT_W-1:0] activeReload;
  logic [CNT_W-1:0] prescCount;
  logic [REP_W-1:0] repCount;
  logic             countDown;
  logic             tick;
  logic             wrap;
  logic             genUpdate;
  logic             repUpdate;

  assign genUpdate = wrEvt && hwdata[EG_UPDATE];
  // counter halts while the active reload value is zero
  assign tick = mode[MD_ENABLE] && (activeReload != '0) && (prescCount == activePresc);
  assign wrap = tick && (countDown ? (counter_value == '0) : (counter_value == activeReload));
  assign repUpdate = wrap && (repCount == '0);
  assign updateEvent = repUpdate || genUpdate;

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !mode[MD_ENABLE] || tick) begin
      prescCount <= '0;
    end else begin
      prescCount <= prescCount + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      activePresc  <= RST_PRESCALE;
      activeReload <= RST_RELOAD;
    end else if (updateEvent) begin
      activePresc  <= prescale_divider;
      activeReload <= reload_value;
    end
  end

  // a software write to the count wins over counting and over update generate
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      counter_value <= RST_COUNT;
      countDown     <= 1'b0;
    end else if (wrCount) begin
      counter_value <= hwdata[CNT_W-1:0];
    end else if (genUpdate) begin
      counter_value <= countDown ? activeReload : '0;
    end else if (tick) begin
      if (mode[MD_CENTER]) begin
        if (!countDown && counter_value == activeReload) begin
          countDown     <= 1'b1;
          counter_value <= counter_value - 1'b1;
        end else if (countDown && counter_value == '0) begin
          countDown     <= 1'b0;
          counter_value <= counter_value + 1'b1;
        end else begin
          counter_value <= countDown ? counter_value - 1'b1 : counter_value + 1'b1;
        end
      end else begin
        countDown <= mode[MD_DIR_DOWN];
        if (wrap) begin
          counter_value <= countDown ? activeReload : '0;
        end else begin
          counter_value <= countDown ? counter_value - 1'b1 : counter_value + 1'b1;
        end
      end
    end
  end

  // a generated update restarts the repetition count as well
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      repCount <= RST_REPEAT;
    end else if (genUpdate || repUpdate) begin
      repCount <= repetition_setting;
    end else if (wrap) begin
      repCount <= repCount - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // dead time and idle entry
  // ----------------------------------------------------------------
  logic        refPol;
  logic        refPrev;
  logic [7:0]  dtCount;
  logic        priDelayed;
  logic        cmpDelayed;
  idle_state_e idleState;
  logic        moe;
  logic        idle_off_state_select;
  logic        run_off_state_select;
  logic        ccE;
  logic        ccnE;
  logic        ccP;
  logic        ccnP;
  logic        oi;
  logic        oin;

  assign moe                   = outCtrl[OC_MAIN_EN];
  assign idle_off_state_select = outCtrl[OC_IDLE_OFF];
  assign run_off_state_select  = outCtrl[OC_RUN_OFF];
  assign ccE  = outCtrl[OC_PRI_EN];
  assign ccnE = outCtrl[OC_CMP_EN];
  assign ccP  = outCtrl[OC_PRI_POL];
  assign ccnP = outCtrl[OC_CMP_POL];
  assign oi   = outCtrl[OC_PRI_IDLE];
  assign oin  = outCtrl[OC_CMP_IDLE];
  assign refPol = reference_waveform;

  // each edge of the reference holds both outputs inactive for the dead time
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      refPrev    <= 1'b0;
      dtCount    <= 8'h00;
      priDelayed <= 1'b0;
      cmpDelayed <= 1'b0;
    end else begin
      refPrev <= refPol;
      if (refPol != refPrev) begin
        // a zero dead time passes the edge straight through
        dtCount    <= deadTime;
        priDelayed <= (deadTime == 8'h00) && refPol;
        cmpDelayed <= (deadTime == 8'h00) && !refPol;
      end else if (dtCount > 8'h01) begin
        dtCount <= dtCount - 1'b1;
      end else begin
        dtCount    <= 8'h00;
        priDelayed <= refPol;
        cmpDelayed <= ~refPol;
      end
    end
  end

  // idle levels wait out the dead time so the pair never overlaps on the way out
  logic [7:0] idleCount;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || moe) begin
      idleState <= DT_IDLE;
      idleCount <= 8'h00;
    end else begin
      unique case (idleState)
        DT_IDLE: begin
          // the forced levels already count as the first dead-time cycle
          if (deadTime <= 8'h01) begin
            idleState <= DT_DONE;
          end else begin
            idleState <= DT_WAIT;
          end
          idleCount <= deadTime - 8'h02;
        end
        DT_WAIT: begin
          if (idleCount == 8'h00) idleState <= DT_DONE;
          else idleCount <= idleCount - 1'b1;
        end
        DT_DONE: idleState <= DT_DONE;
        default: idleState <= DT_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output state table
  // ----------------------------------------------------------------
  pin_pair_s next_pins;
  always_comb begin
    next_pins = '0;
    if (moe) begin
      unique case ({ccE, ccnE})
        2'b00: next_pins = '{run_off_state_select & ccP, 1'b0, run_off_state_select & ccnP, 1'b0};
        2'b01: next_pins = '{run_off_state_select & ccP, run_off_state_select, refPol ^ ccnP, 1'b1};
        2'b10: next_pins = '{refPol ^ ccP, 1'b1, run_off_state_select & ccnP, run_off_state_select};
        2'b11: next_pins = '{priDelayed ^ ccP, 1'b1, cmpDelayed ^ ccnP, 1'b1};
      endcase
    end else if ({ccE, ccnE} == 2'b00) begin
      next_pins = '{ccP, idle_off_state_select, ccnP, idle_off_state_select};
    end else if ((idleState == DT_DONE) && ((ccP ^ oi) ^ (ccnP ^ oin))) begin
      next_pins = '{oi, idle_off_state_select, oin, idle_off_state_select};
    end else begin
      next_pins = '{ccP, idle_off_state_select, ccnP, idle_off_state_select};
    end
  end
  // the forced levels must appear without waiting for a clock edge
  assign pins = next_pins;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // captured in the address phase so it stands through the data phase
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      unique case (haddr[7:0])
        OFS_COUNT:    hrdata <= {16'h0000, counter_value};
        OFS_PRESCALE: hrdata <= {16'h0000, prescale_divider};
        OFS_RELOAD:   hrdata <= {16'h0000, reload_value};
        OFS_REPEAT:   hrdata <= {24'h00_0000, repetition_setting};
        OFS_OUTCTRL:  hrdata <= {8'h00, deadTime, 7'h00, outCtrl};
        OFS_MODE:     hrdata <= {29'h0000_0000, mode};
        OFS_STATUS:   hrdata <= {16'h0000, repCount, 4'h0, idleState, countDown};
        default:      hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : timer_base_outputs

/* File: bench/timer_base_monitor.sv */
// checker: output-state and update-event assertions on the timer block ports
module timer_base_monitor
  import timer_base_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int REP_W = 8
) (
  // clock and reset
  input logic        sys_clk,
  input logic        sys_rst,
  // bus
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [2:0]  hsize,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp,
  // waveform and pins
  input logic        reference_waveform,
  input pin_pair_s   pins,
  input logic        updateEvent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       dpWr;
  logic [7:0] dpAddr;
  logic [8:0] ctl;
  logic       moe, idleOff, runOff, priEn, cmpEn, pPol, cPol;
  assign {moe, idleOff, runOff} = ctl[8:6];
  assign {cPol, cmpEn, pPol, priEn} = ctl[3:0];
  always_ff @(posedge sys_clk) begin
    dpWr   <= !sys_rst && hsel && hready && htrans[1] && hwrite;
    dpAddr <= haddr[7:0];
  end
  // mirror of the output control word, so pins can be judged without peeking inside
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctl <= '0;
    end else if (dpWr && dpAddr == OFS_OUTCTRL) begin
      ctl <= hwdata[8:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_run_released: assert property (moe && !runOff && !priEn |-> !pins.priDrive && !pins.priOut)
    else $error("released primary driven");
  a_pri_follow: assert property (moe && priEn && !cmpEn |-> pins.priDrive && pins.priOut == (reference_waveform ^ pPol))
    else $error("primary not following");
  a_cmp_follow: assert property (moe && cmpEn && !priEn |-> pins.cmpDrive && pins.cmpOut == (reference_waveform ^ cPol))
    else $error("complementary not following");
  a_pair_safe: assert property (moe && priEn && cmpEn |-> pins.priDrive && pins.cmpDrive && !((pins.priOut ^ pPol) && (pins.cmpOut ^ cPol)))
    else $error("pair overlap or undriven");
  a_off_undriven: assert property (moe && runOff && !priEn && !cmpEn |-> pins == {pPol, 1'b0, cPol, 1'b0})
    else $error("off pair not at polarity");
  a_off_inactive: assert property (moe && runOff && !priEn && cmpEn |-> pins.priDrive && pins.priOut == pPol)
    else $error("unused partner not inactive");
  a_idle_released: assert property (!moe && !idleOff |-> !pins.priDrive && !pins.cmpDrive)
    else $error("idle outputs driven");
  a_idle_driven: assert property (!moe && idleOff |-> pins.priDrive && pins.cmpDrive)
    else $error("idle outputs released");
  a_update_now: assert property (dpWr && dpAddr == OFS_EVTGEN && hwdata[EG_UPDATE] |-> updateEvent)
    else $error("no update on generate");
endmodule : timer_base_monitor

bind timer_base_outputs timer_base_monitor #(.CNT_W(CNT_W), .REP_W(REP_W)) u_mon (
  .sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .reference_waveform, .pins, .updateEvent
);

/* File: bench/pad_switch_model.sv */
// model: gate-driver inputs of the power switches fed by the output pair
module pad_switch_model
  import timer_base_pkg::*;
(
  // pair from the timer
  input pin_pair_s pins,
  // gate-driver inputs
  output logic     gateHigh,
  output logic     gateLow
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pins fall to the driver pull-down, never a stale level
  assign gateHigh = pins.priDrive ? pins.priOut : 1'b0;
  assign gateLow  = pins.cmpDrive ? pins.cmpOut : 1'b0;
endmodule : pad_switch_model

/* File: bench/test_timer_base_outputs.sv */
// testbench: registers, output states, dead time and update timing
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_timer_base_outputs import timer_base_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic        refWave = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0000_0000;
  logic [31:0] hwdata  = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, updateEvent, gateHigh, gateLow;
  pin_pair_s   pins;
  int          mismatches, testsRun, cycles;
  timer_base_outputs #(.CNT_W(16), .REP_W(8)) u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .reference_waveform(refWave), .pins(pins),
    .updateEvent(updateEvent)
  );
  pad_switch_model u_pads (.pins(pins), .gateHigh(gateHigh), .gateLow(gateLow));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic chkRd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    `CHK(n, e, q)
  endtask : chkRd
  task automatic waitUpd(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (updateEvent !== 1'b1 && n < 500);
  endtask : waitUpd
  function automatic pin_pair_s expPins(input logic [6:0] c, input logic r);
    pin_pair_s e;
    if (!c[6]) begin
      e = '{c[1], c[5], c[3], c[5]};
    end else if (c[0] && c[2]) begin
      e = '{r ^ c[1], 1'b1, !r ^ c[3], 1'b1};
    end else begin
      e = '{c[0] ? r ^ c[1] : c[4] & c[1], c[0] | c[4] & c[2], c[2] ? r ^ c[3] : c[4] & c[3], c[2] | c[4] & c[0]};
    end
    return e;
  endfunction : expPins
  task automatic t_regs();
    chkRd("reload", OFS_RELOAD, {16'h0000, RST_RELOAD});
    chkRd("prescale", OFS_PRESCALE, 32'h0000_0000);
    wr(8'h00, 32'hffff_ffff);
    chkRd("unmapped", 8'h00, 32'h0000_0000);
    wr(OFS_RELOAD, 32'h0000_abcd);
    chkRd("reload", OFS_RELOAD, 32'h0000_abcd);
  endtask : t_regs
  task automatic t_outputs();
    logic [6:0] c;
    pin_pair_s  e;
    for (int i = 0; i < 256; i++) begin
      c = i[7:1];
      if (!c[0] && !c[2] && (c[1] || c[3])) continue;
      wr(OFS_OUTCTRL, {23'h00_0000, c[6:4], c[3], c[1], c[3:0]});
      refWave <= i[0];
      @(posedge sys_clk);
      #1;
      e = expPins(c, i[0]);
      `CHK("pins", e, pins)
      `CHK("gate", e.priDrive & e.priOut, gateHigh)
      `CHK("gate low", e.cmpDrive & e.cmpOut, gateLow)
      @(posedge sys_clk);
    end
  endtask : t_outputs
  task automatic t_deadtime();
    refWave <= 1'b0;
    wr(OFS_OUTCTRL, 32'h0003_0105);
    repeat (4) @(posedge sys_clk);
    refWave <= 1'b1;
    @(posedge sys_clk);
    #1;
    `CHK("gap", 2'h0, {pins.priOut, pins.cmpOut})
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("gap end", 2'h0, {pins.priOut, pins.cmpOut})
    @(posedge sys_clk);
    #1;
    `CHK("active", 2'h2, {pins.priOut, pins.cmpOut})
    @(posedge sys_clk);
    wr(OFS_OUTCTRL, 32'h0003_0015);
    #1;
    `CHK("forced", 4'h0, pins)
    @(posedge sys_clk);
    #1;
    `CHK("held", 4'h0, pins)
    @(posedge sys_clk);
    #1;
    `CHK("still held", 4'h0, pins)
    @(posedge sys_clk);
    #1;
    `CHK("idle", 4'h8, pins)
    @(posedge sys_clk);
  endtask : t_deadtime
  task automatic t_counter();
    int n;
    logic [31:0] q;
    wr(OFS_RELOAD, 32'h0000_0003);
    wr(OFS_PRESCALE, 32'h0000_0001);
    wr(OFS_REPEAT, 32'h0000_0001);
    wr(OFS_MODE, 32'h0000_0001);
    wr(OFS_EVTGEN, 32'h0000_0001);
    waitUpd(n);
    waitUpd(n);
    `CHK("up period", 16, n)
    @(posedge sys_clk);
    wr(OFS_MODE, 32'h0000_0003);
    wr(OFS_EVTGEN, 32'h0000_0001);
    waitUpd(n);
    waitUpd(n);
    `CHK("down period", 16, n)
    @(posedge sys_clk);
    wr(OFS_PRESCALE, 32'h0000_0003);
    waitUpd(n);
    `CHK("old prescale", 1'b1, n <= 16)
    waitUpd(n);
    `CHK("new prescale", 32, n)
    @(posedge sys_clk);
    wr(OFS_RELOAD, 32'h0000_0000);
    wr(OFS_EVTGEN, 32'h0000_0001);
    xfer(1'b0, OFS_COUNT, 32'h0000_0000, q);
    repeat (20) @(posedge sys_clk);
    chkRd("stopped", OFS_COUNT, q);
  endtask : t_counter
  task automatic results();
    if (mismatches == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_outputs();
    t_deadtime();
    t_counter();
    results();
  end
endmodule : test_timer_base_outputs
